/* File: shared/dtmr_pkg.sv */
// constants and carrier types for the dual 6-bit down timer block
// assumes one 40 MHz system clock that also feeds the pre-divider
package dtmr_pkg;
	localparam int DTMR_CNT_W  = 6;
	localparam int DTMR_SEL_W  = 3;
	localparam int DTMR_OP_W   = 9;
	localparam int DTMR_STAGES = 15;
	localparam int DTMR_TAPS   = 8;
	// operand field positions
	localparam int DTMR_SEL_MSB = 8;
	localparam int DTMR_SEL_LSB = 6;
	localparam int DTMR_VAL_MSB = 5;
	// clock select code to divider stage; code 3 is the tone clock
	localparam int DTMR_TAP_STAGE [DTMR_TAPS] = '{9, 3, 15, 0, 5, 7, 11, 13};
	localparam logic [2:0] DTMR_SEL_TONE    = 3'h3;
	localparam logic [2:0] DTMR_SEL_ONE_RST = 3'h1;
	localparam logic [2:0] DTMR_SEL_TWO_RST = 3'h5;
	localparam logic [5:0] DTMR_UFLOW_VAL   = 6'h3f;
	localparam logic [5:0] DTMR_COUNT_RST   = 6'h00;
	localparam logic [5:0] DTMR_ZERO        = 6'h00;
	localparam logic [14:0] DTMR_DIV_RST    = 15'h0000;
	// timer two flag group bit positions
	localparam int DTMR_FLAG_RELOAD = 1;
	localparam int DTMR_FLAG_HOLD   = 2;

	typedef struct packed {
		logic       strobe;
		logic [8:0] operand;
	} dtmr_load_t;

	typedef struct packed {
		logic       set;
		logic       clear;
		logic [3:0] bits;
	} dtmr_flag_op_t;

	typedef struct packed {
		logic [1:0] irq_en;
		logic [1:0] wake_en;
		logic       one_reload;
		logic       conv_en;
		logic       halted;
	} dtmr_ctrl_t;

	typedef struct packed {
		logic [5:0] count;
		logic [2:0] sel;
		logic       running;
		logic       armed;
		logic       reload_q;
		logic       uflow;
	} dtmr_chan_state_t;

	typedef struct packed {
		logic [14:0] cnt;
		logic [7:0]  ticks;
	} dtmr_div_state_t;
endpackage

/* File: verilog/dtmr_prediv.sv */
// pre-divider: 15 stages fed by the system clock, one tick per tap
// assumes tone_tick_i is already synchronous, one cycle wide
`timescale 1ns/1ps
module dtmr_prediv (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_n_i,
	input  wire logic       tone_tick_i,
	output logic [7:0]      ticks_o
);
	import dtmr_pkg::*;

	dtmr_div_state_t s;
	dtmr_div_state_t next_s;
	logic [7:0]      hit;

	// a tick marks the rising edge of stage n, once per 2**n input cycles
	for (genvar g = 0; g < DTMR_TAPS; g++) begin : g_tap
		localparam int N = DTMR_TAP_STAGE[g];
		if (N == 0) begin : g_tone
			assign hit[g] = tone_tick_i;
		end else begin : g_stage
			assign hit[g] = (s.cnt[N-1:0] == N'((1 << (N - 1)) - 1));
		end
	end

	always_comb begin
		next_s       = s;
		next_s.cnt   = 15'(s.cnt + 15'h0001);
		next_s.ticks = hit;
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '{cnt: DTMR_DIV_RST, ticks: 8'h00};
		end else begin
			s <= next_s;
		end
	end

	assign ticks_o = s.ticks;
endmodule

/* File: verilog/dtmr_channel.sv */
// one 6-bit down counter with tap select, one-shot or auto-reload
// assumes load strobes and reload level come from logic on sys_clk_i
`timescale 1ns/1ps
module dtmr_channel #(
	parameter logic [2:0] SEL_RST = 3'h1
) (
	input  wire logic                sys_clk_i,
	input  wire logic                reset_n_i,
	input  wire logic                wdt_reset_i,
	input  wire dtmr_pkg::dtmr_load_t load_i,
	input  wire logic                reload_i,
	input  wire logic [7:0]          ticks_i,
	output logic [5:0]               count_o,
	output logic [2:0]               sel_o,
	output logic                     running_o,
	output logic                     uflow_o
);
	import dtmr_pkg::*;

	dtmr_chan_state_t s;
	dtmr_chan_state_t next_s;

	always_comb begin
		next_s          = s;
		next_s.uflow    = 1'b0;
		next_s.reload_q = reload_i;
		// a load not yet followed by an underflow: dropping reload stops now
		if (s.reload_q && !reload_i && s.armed) begin
			next_s.running = 1'b0;
		end
		if (s.running && ticks_i[s.sel]) begin
			next_s.count = 6'(s.count - 6'h01);
			if (s.count == DTMR_ZERO) begin
				next_s.uflow = 1'b1;
				next_s.armed = 1'b0;
				next_s.count = DTMR_UFLOW_VAL;
				if (!reload_i) begin
					next_s.running = 1'b0;
				end
			end
		end
		if (load_i.strobe) begin
			next_s.count   = load_i.operand[DTMR_VAL_MSB:0];
			next_s.sel     = load_i.operand[DTMR_SEL_MSB:DTMR_SEL_LSB];
			next_s.running = 1'b1;
			next_s.armed   = 1'b1;
		end
		// watchdog leaves the tap selection alone
		if (wdt_reset_i) begin
			next_s.count    = DTMR_COUNT_RST;
			next_s.running  = 1'b0;
			next_s.armed    = 1'b0;
			next_s.reload_q = 1'b0;
			next_s.uflow    = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '{count: DTMR_COUNT_RST, sel: SEL_RST, default: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign count_o   = s.count;
	assign sel_o     = s.sel;
	assign running_o = s.running;
	assign uflow_o   = s.uflow;
endmodule

/* File: verilog/dtmr_top.sv */
// dual 6-bit down timers: request, start condition, irq, wake and gate
// assumes all strobes and levels come from core logic on sys_clk_i;
// only tone_clk_i is foreign and is synchronised here
//
// Notes on behaviour
// - two 6-bit down counters, started by load
// - timer one underflow sets request, may stop
// - timer two underflow sets request, may stop
// - timer one request and irq enable interrupt
// - timer one request wakes halt, sets start
// - timer two request and irq enable interrupt
// - timer two request wakes halt, sets start
// - power-on: timer one uses tap three
// - power-on: timer two uses tap seven
// - watchdog reset keeps clock selections
// - operand: three select bits, six value bits
// - select code maps to divider tap
// - taps are pre-divider stage outputs, code 3 the tone clock
// - timeout is value plus partial tick
// - reload restarts from 3f, 64 ticks
// - reload off: stop on underflow or now
// - flag bit one controls timer two reload
// - timer two gate set, dropped on underflow
// - gate hold keeps gate across underflow
// - timer one start clears with request/wake
// - timer two start clears with request/wake
`timescale 1ns/1ps
module dtmr_top (
	input  wire logic                  sys_clk_i,
	input  wire logic                  reset_n_i,
	input  wire logic                  wdt_reset_i,
	input  wire logic                  tone_clk_i,
	input  wire dtmr_pkg::dtmr_load_t  load_one_i,
	input  wire dtmr_pkg::dtmr_load_t  load_two_i,
	input  wire dtmr_pkg::dtmr_flag_op_t flags_two_i,
	input  wire logic [1:0]            clear_request_i,
	input  wire dtmr_pkg::dtmr_ctrl_t  ctrl_i,
	output logic [5:0]                 count_one_o,
	output logic [5:0]                 count_two_o,
	output logic [1:0]                 running_o,
	output logic [1:0]                 underflow_o,
	output logic [1:0]                 request_o,
	output logic [1:0]                 start_cond_o,
	output logic [1:0]                 irq_o,
	output logic                       wake_o,
	output logic                       converter_gate_o,
	output logic                       reload_two_o,
	output logic                       gate_hold_o
);
	import dtmr_pkg::*;

	typedef struct packed {
		logic [1:0] req;
		logic [1:0] scond;
		logic [1:0] irq;
		logic       wake;
		logic       gate;
		logic       reload_two;
		logic       hold;
		logic       tone_s1;
		logic       tone_s2;
		logic       tone_q;
	} dtmr_top_state_t;

	dtmr_top_state_t s;
	dtmr_top_state_t next_s;

	logic [7:0] ticks;
	logic       tone_tick;
	logic [1:0] uf;
	logic [1:0] ie;
	logic [1:0] we;
	logic [1:0] run;
	logic [2:0] sel_one;
	logic [2:0] sel_two;
	logic [5:0] cnt_one;
	logic [5:0] cnt_two;

	assign ie = ctrl_i.irq_en;
	assign we = ctrl_i.wake_en;

	// edge taken between second and third flop, never off the first
	assign tone_tick = s.tone_s2 & ~s.tone_q;

	dtmr_prediv u_prediv (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.tone_tick_i(tone_tick),
		.ticks_o    (ticks)
	);

	dtmr_channel #(
		.SEL_RST(DTMR_SEL_ONE_RST)
	) u_first_timer (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.wdt_reset_i(wdt_reset_i),
		.load_i     (load_one_i),
		.reload_i   (ctrl_i.one_reload),
		.ticks_i    (ticks),
		.count_o    (cnt_one),
		.sel_o      (sel_one),
		.running_o  (run[0]),
		.uflow_o    (uf[0])
	);

	dtmr_channel #(
		.SEL_RST(DTMR_SEL_TWO_RST)
	) u_second_timer (
		.sys_clk_i  (sys_clk_i),
		.reset_n_i  (reset_n_i),
		.wdt_reset_i(wdt_reset_i),
		.load_i     (load_two_i),
		.reload_i   (s.reload_two),
		.ticks_i    (ticks),
		.count_o    (cnt_two),
		.sel_o      (sel_two),
		.running_o  (run[1]),
		.uflow_o    (uf[1])
	);

	always_comb begin
		next_s         = s;
		next_s.tone_s1 = tone_clk_i;
		next_s.tone_s2 = s.tone_s1;
		next_s.tone_q  = s.tone_s2;
		// an underflow in the clearing cycle still leaves the flag set
		next_s.req   = (s.req & ~clear_request_i) | uf;
		// start condition lives only while request and wake enable both hold
		next_s.scond = (s.scond | (s.req & ~ie & we)) & next_s.req & we;
		next_s.irq   = s.req & ie;
		next_s.wake  = ctrl_i.halted & |(s.req & ~ie & we);
		// clear first so a simultaneous set of the same bit wins
		if (flags_two_i.clear) begin
			if (flags_two_i.bits[DTMR_FLAG_RELOAD]) begin
				next_s.reload_two = 1'b0;
			end
			if (flags_two_i.bits[DTMR_FLAG_HOLD]) begin
				next_s.hold = 1'b0;
			end
		end
		if (flags_two_i.set) begin
			if (flags_two_i.bits[DTMR_FLAG_RELOAD]) begin
				next_s.reload_two = 1'b1;
			end
			if (flags_two_i.bits[DTMR_FLAG_HOLD]) begin
				next_s.hold = 1'b1;
			end
		end
		if (uf[1] && !s.hold) begin
			next_s.gate = 1'b0;
		end
		// a fresh load in converter mode opens a new gate window
		if (load_two_i.strobe && ctrl_i.conv_en) begin
			next_s.gate = 1'b1;
		end
		if (wdt_reset_i) begin
			next_s.req        = 2'h0;
			next_s.scond      = 2'h0;
			next_s.irq        = 2'h0;
			next_s.wake       = 1'b0;
			next_s.gate       = 1'b0;
			next_s.reload_two = 1'b0;
			next_s.hold       = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// all of these are flops in this module or in the channels
	assign count_one_o      = cnt_one;
	assign count_two_o      = cnt_two;
	assign running_o        = run;
	assign underflow_o      = uf;
	assign request_o        = s.req;
	assign start_cond_o     = s.scond;
	assign irq_o            = s.irq;
	assign wake_o           = s.wake;
	assign converter_gate_o = s.gate;
	assign reload_two_o     = s.reload_two;
	assign gate_hold_o      = s.hold;

	// checks below run on the system clock and idle in reset
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	// an underflow of a running channel, without load or watchdog
	sequence one_wraps_s;
		run[0] && ticks[sel_one] && cnt_one == DTMR_ZERO
			&& !load_one_i.strobe && !wdt_reset_i;
	endsequence

	sequence two_wraps_s;
		run[1] && ticks[sel_two] && cnt_two == DTMR_ZERO
			&& !load_two_i.strobe && !wdt_reset_i;
	endsequence

	sequence one_ticks_s;
		run[0] && ticks[sel_one] && cnt_one != DTMR_ZERO
			&& !load_one_i.strobe && !wdt_reset_i;
	endsequence

	count_step_a: assert property (one_ticks_s |=> cnt_one == $past(cnt_one) - 6'h01)
		else $error("timer one did not step down by one");

	one_uflow_a: assert property (one_wraps_s |=> uf[0] ##1 request_o[0])
		else $error("timer one wrap without request");

	two_uflow_a: assert property (two_wraps_s |=> uf[1] ##1 request_o[1])
		else $error("timer two wrap without request");

	one_stop_a: assert property (one_wraps_s and !ctrl_i.one_reload |=> !run[0])
		else $error("timer one kept running without reload");

	two_stop_a: assert property (two_wraps_s and !s.reload_two |=> !run[1])
		else $error("timer two kept running without reload");

	reload_restart_a: assert property (one_wraps_s and ctrl_i.one_reload
		|=> run[0] && cnt_one == DTMR_UFLOW_VAL)
		else $error("reload did not restart from 3f");

	irq_one_a: assert property (request_o[0] && ie[0] && !wdt_reset_i |=> irq_o[0])
		else $error("timer one interrupt missing");

	irq_two_a: assert property (request_o[1] && ie[1] && !wdt_reset_i |=> irq_o[1])
		else $error("timer two interrupt missing");

	irq_cause_a: assert property (irq_o != 2'h0 |-> ($past(s.req) & $past(ie)) != 2'h0)
		else $error("interrupt without request and enable");

	wake_one_a: assert property (ctrl_i.halted && request_o[0] && !ie[0] && we[0]
		&& !wdt_reset_i |=> wake_o)
		else $error("timer one did not wake from halt");

	start_one_a: assert property (request_o[0] && !ie[0] && we[0] && !clear_request_i[0]
		&& !wdt_reset_i |=> start_cond_o[0])
		else $error("timer one start condition not set");

	start_two_a: assert property (request_o[1] && !ie[1] && we[1] && !clear_request_i[1]
		&& !wdt_reset_i |=> start_cond_o[1])
		else $error("timer two start condition not set");

	start_drop_a: assert property (!we[0] || (clear_request_i[0] && !uf[0])
		|=> !start_cond_o[0])
		else $error("timer one start condition not cleared");

	start_two_drop_a: assert property (!we[1] || (clear_request_i[1] && !uf[1])
		|=> !start_cond_o[1])
		else $error("timer two start condition not cleared");

	req_sticky_a: assert property (request_o[0] && !clear_request_i[0] && !wdt_reset_i
		|=> request_o[0])
		else $error("request dropped without clear");

	set_wins_a: assert property (uf[1] && clear_request_i[1] && !wdt_reset_i
		|=> request_o[1])
		else $error("underflow lost against clear");

	sel_keep_a: assert property (wdt_reset_i |=> sel_one == $past(sel_one)
		&& sel_two == $past(sel_two))
		else $error("watchdog changed a clock selection");

	load_take_a: assert property (load_two_i.strobe && !wdt_reset_i
		|=> run[1] && cnt_two == $past(load_two_i.operand[5:0])
		&& sel_two == $past(load_two_i.operand[8:6]))
		else $error("load not taken");

	gate_drop_a: assert property (uf[1] && !s.hold && !load_two_i.strobe |=> !converter_gate_o)
		else $error("gate not dropped on underflow");

	gate_hold_a: assert property (uf[1] && s.hold && converter_gate_o && !wdt_reset_i
		|=> converter_gate_o && request_o[1])
		else $error("held gate dropped on underflow");

	gate_open_a: assert property (load_two_i.strobe && ctrl_i.conv_en && !wdt_reset_i
		|=> converter_gate_o)
		else $error("converter gate not opened by load");

	reload_flag_a: assert property (flags_two_i.set && flags_two_i.bits[DTMR_FLAG_RELOAD]
		&& !wdt_reset_i |=> reload_two_o)
		else $error("reload flag not set");

	reload_off_a: assert property (s.reload_two && !next_s.reload_two && u_second_timer.s.armed
		&& !load_two_i.strobe ##1 1'b1 |=> !run[1])
		else $error("timer two not stopped when reload dropped");
endmodule

/* File: test/test_dual_six_bit_down_timers.sv */
// self-checking bench for the dual 6-bit down timer block
// assumes dtmr_pkg is compiled first; the bench drives every port directly
`timescale 1ns/1ps
module test_dual_six_bit_down_timers;
	import dtmr_pkg::*;
	logic          sys_clk_i       = 1'b0;
	logic          reset_n_i       = 1'b0;
	logic          wdt_reset_i     = 1'b0;
	logic          tone_clk_i      = 1'b0;
	logic          tone_en         = 1'b0;
	dtmr_load_t    load_one_i      = '0;
	dtmr_load_t    load_two_i      = '0;
	dtmr_flag_op_t flags_two_i     = '0;
	logic [1:0]    clear_request_i = 2'h0;
	dtmr_ctrl_t    ctrl_i          = '0;
	logic [5:0]    count_one_o;
	logic [5:0]    count_two_o;
	logic [1:0]    running_o;
	logic [1:0]    underflow_o;
	logic [1:0]    request_o;
	logic [1:0]    start_cond_o;
	logic [1:0]    irq_o;
	logic          wake_o;
	logic          converter_gate_o;
	logic          reload_two_o;
	logic          gate_hold_o;
	int            n_mismatch      = 0;
	int            total_checks    = 0;
	int            cyc             = 0;

	always #12.5 sys_clk_i = ~sys_clk_i;
	// tone clock period is 20 system cycles, edges land on falling sys edges
	always #250 tone_clk_i = tone_en & ~tone_clk_i;

	dtmr_top dtmr_top_i (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .wdt_reset_i(wdt_reset_i),
		.tone_clk_i(tone_clk_i), .load_one_i(load_one_i), .load_two_i(load_two_i),
		.flags_two_i(flags_two_i), .clear_request_i(clear_request_i), .ctrl_i(ctrl_i),
		.count_one_o(count_one_o), .count_two_o(count_two_o), .running_o(running_o),
		.underflow_o(underflow_o), .request_o(request_o), .start_cond_o(start_cond_o),
		.irq_o(irq_o), .wake_o(wake_o), .converter_gate_o(converter_gate_o),
		.reload_two_o(reload_two_o), .gate_hold_o(gate_hold_o)
	);

	task finish_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 95000) begin
			n_mismatch++;
			finish_test;
		end
	end

	task automatic step(input int n = 1);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask

	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic load(input int idx, input logic [8:0] op);
		if (idx == 0)
			load_one_i = '{1'b1, op};
		else
			load_two_i = '{1'b1, op};
		step();
		load_one_i.strobe = 1'b0;
		load_two_i.strobe = 1'b0;
	endtask

	task automatic wait_uf(input int idx, input int limit, output int n);
		n = 0;
		while (underflow_o[idx] !== 1'b1 && n < limit) begin
			step();
			n++;
		end
	endtask

	task automatic clr(input int idx);
		clear_request_i[idx] = 1'b1;
		step();
		clear_request_i = 2'h0;
	endtask

	task automatic flag2(input logic set, input logic [3:0] bits);
		flags_two_i = '{set, ~set, bits};
		step();
		flags_two_i = '0;
	endtask

	task automatic t_one_shot;
		int n;
		ctrl_i.irq_en = 2'b01;
		load(0, 9'h042);
		chk("count one load", count_one_o, 6'h02);
		chk("running one", running_o[0], 1'b1);
		wait_uf(0, 40, n);
		chk("t1 tap three time", n >= 16 && n <= 27, 1'b1);
		chk("count one wrap", count_one_o, DTMR_UFLOW_VAL);
		chk("t1 stops", running_o[0], 1'b0);
		step();
		chk("t1 request", request_o[0], 1'b1);
		step();
		chk("t1 irq", irq_o[0], 1'b1);
		chk("t1 no start cond", start_cond_o[0], 1'b0);
		step(30);
		chk("t1 request sticky", request_o[0], 1'b1);
		chk("t1 held", count_one_o, 6'h3f);
		clr(0);
		step(2);
		chk("t1 request clear", {request_o[0], irq_o[0]}, 2'b00);
		ctrl_i.irq_en = 2'b00;
		load(0, 9'h045);
		chk("t1 restart", {running_o[0], count_one_o}, 7'h45);
		step(3);
		load(0, 9'h043);
		chk("t1 reload count", count_one_o, 6'h03);
		wait_uf(0, 40, n);
		step();
		clr(0);
	endtask

	task automatic t_taps;
		int n;
		int per[8] = '{512, 8, 32768, 20, 32, 128, 2048, 8192};
		for (int c = 0; c < 8; c++) begin
			tone_en = (c == 3);
			if (c == 2) begin
				// one tick only: a full second period would eat most of the budget
				load(1, {3'(c), 6'h00});
				wait_uf(1, per[c] + 10, n);
				chk("t2 tap fifteen", n > 0 && n <= per[c] + 8, 1'b1);
			end else begin
				load(1, {3'(c), 6'h01});
				wait_uf(1, 2 * per[c] + 10, n);
				chk("t2 tap period", n > per[c] && n <= 2 * per[c] + 8, 1'b1);
			end
			chk("t2 stops", running_o[1], 1'b0);
			tone_en = 1'b0;
		end
		step();
		chk("t2 request", request_o[1], 1'b1);
		clr(1);
	endtask

	task automatic t_reload;
		int n;
		load(0, 9'h041);
		ctrl_i.one_reload = 1'b1;
		wait_uf(0, 30, n);
		chk("t1 reload runs", {running_o[0], count_one_o}, 7'h7f);
		step();
		wait_uf(0, 600, n);
		chk("t1 reload period", n == 511, 1'b1);
		chk("t1 request kept", request_o[0], 1'b1);
		ctrl_i.one_reload = 1'b0;
		step();
		wait_uf(0, 600, n);
		chk("t1 stops after reload off", running_o[0], 1'b0);
		load(0, 9'h07f);
		ctrl_i.one_reload = 1'b1;
		step(2);
		ctrl_i.one_reload = 1'b0;
		step(2);
		chk("t1 stops at once", running_o[0], 1'b0);
		clr(0);
	endtask

	task automatic t_gate;
		int n;
		ctrl_i.conv_en = 1'b1;
		load(1, 9'h041);
		chk("gate opens", converter_gate_o, 1'b1);
		flag2(1'b1, 4'b0110);
		chk("t2 flags set", {reload_two_o, gate_hold_o}, 2'b11);
		wait_uf(1, 30, n);
		chk("t2 reloads", running_o[1], 1'b1);
		step(2);
		chk("gate held", {converter_gate_o, request_o[1]}, 2'b11);
		clr(1);
		flag2(1'b0, 4'b0100);
		chk("hold off", gate_hold_o, 1'b0);
		wait_uf(1, 600, n);
		step(2);
		chk("gate drops", {converter_gate_o, running_o[1]}, 2'b01);
		flag2(1'b0, 4'b0010);
		chk("reload two off", reload_two_o, 1'b0);
		wait_uf(1, 600, n);
		chk("t2 stops", running_o[1], 1'b0);
		ctrl_i.conv_en = 1'b0;
		step();
		clr(1);
	endtask

	task automatic t_wake(input int idx);
		int n;
		ctrl_i.halted = 1'b1;
		ctrl_i.wake_en[idx] = 1'b1;
		load(idx, 9'h040);
		wait_uf(idx, 20, n);
		step(3);
		chk("wake", {wake_o, start_cond_o[idx], irq_o[idx]}, 3'b110);
		// timer one drops its request, timer two its wake enable
		if (idx == 0)
			clr(0);
		else
			ctrl_i.wake_en[1] = 1'b0;
		step(3);
		chk("start cond clear", {wake_o, start_cond_o[idx]}, 2'b00);
		ctrl_i.halted = 1'b0;
		ctrl_i.wake_en = 2'b00;
		clr(idx);
	endtask

	task automatic t_wdt;
		load(1, 9'h17f);
		step(5);
		wdt_reset_i = 1'b1;
		step();
		wdt_reset_i = 1'b0;
		chk("wdt clears t2", {running_o[1], count_two_o}, 7'h00);
	endtask

	initial begin
		repeat (10) @(posedge sys_clk_i);
		#2;
		reset_n_i = 1'b1;
		chk("reset state", {running_o, request_o, count_one_o}, 8'h00);
		step();
		t_one_shot;
		t_taps;
		t_reload;
		t_gate;
		t_wake(0);
		t_wake(1);
		t_wdt;
		finish_test;
	end
endmodule
